// ===== core/lke_pkg.sv
package lke_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [11:0] OFS_CONTROL  = 12'h100;
   localparam logic [11:0] OFS_INPUT    = 12'h104;
   localparam logic [11:0] OFS_OUTPUT   = 12'h108;
   localparam logic [11:0] OFS_STATUS   = 12'h10c;
   localparam logic [11:0] OFS_EVT_STAT = 12'h110;
   localparam logic [11:0] OFS_EVT_MASK = 12'h114;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTL_EMUL_ON   = 0;
   localparam int CTL_EMUL_INT  = 1;
   localparam int CTL_CHAR_WAIT = 2;
   localparam int CTL_IRQ_EN    = 3;
   localparam int CTL_A20_SEQ   = 5;
   localparam int CTL_A20_STATE = 8;

   // ----------------------------------------
   // Legacy ports and commands
   // ----------------------------------------
   localparam logic [7:0] PORT_DATA   = 8'h60;
   localparam logic [7:0] PORT_CMD    = 8'h64;
   localparam logic [7:0] CMD_A20_SEQ = 8'hd1;
   localparam int         A20_DATA_BIT = 1;

   // ----------------------------------------
   // Event bits of the interrupt status
   // ----------------------------------------
   localparam int EV_WR_DATA = 0;
   localparam int EV_WR_CMD  = 1;
   localparam int EV_RD_DATA = 2;
   localparam int EV_A20     = 3;
   localparam int EV_NUM     = 4;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0]        RST_BYTE = 8'h00;
   localparam logic [EV_NUM-1:0] RST_MASK = 4'h0;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic parity;
      logic timeout;
      logic aux_full_flag;
      logic inhibit_off;
      logic cmd_data;
      logic sys_flag;
      logic input_full;
      logic result_buffer_loaded;
   } lke_status_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } lke_port_req_t;

endpackage

// ===== core/lke_sync.sv
`timescale 1ns/1ps
module lke_sync (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rst_n,
   // Level in and out
   input  wire logic din,
   output logic      dout
);

   logic meta;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         dout <= 1'b0;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule // lke_sync

// ===== core/lke_evt_irq.sv
`timescale 1ns/1ps
module lke_evt_irq (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst_n,
   // Events
   input  wire logic [lke_pkg::EV_NUM-1:0] evt,
   // Software access
   input  wire logic                       stat_rd,
   input  wire logic                       mask_wr,
   input  wire logic [lke_pkg::EV_NUM-1:0] mask_wdata,
   output logic      [lke_pkg::EV_NUM-1:0] stat,
   output logic      [lke_pkg::EV_NUM-1:0] mask,
   // Interrupt line
   output logic                            irq
);

   // ----------------------------------------
   // Sticky bits, a new event beats the read clear
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < lke_pkg::EV_NUM; i++) begin : g_evt
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               stat[i] <= 1'b0;
            end else if (evt[i]) begin
               stat[i] <= 1'b1;
            end else if (stat_rd) begin
               stat[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= lke_pkg::RST_MASK;
      end else if (mask_wr) begin
         mask <= mask_wdata;
      end
   end

   assign irq = |(stat & mask);

endmodule // lke_evt_irq

// ===== core/lke_emul.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Port 60H read returns output byte
// - Status bit 7 parity error, resets zero
// - Status bit 6 timeout, resets zero
// - IRQ12 when aux, loaded, enable set
// - Status bit 4 shows keyboard not inhibited
// - Write 60H clears, 64H sets cmd bit
// - Status bit 2 software flag, no effect
// - Port writes set input full, except A20
// - Input full and enabled raise emulation interrupt
// - Port 60H read clears result loaded; a status write in the same cycle wins
// - IRQ1 while loaded, enabled, aux clear
// - Not loaded plus char-waiting raises emulation interrupt
// - Ports decoded only while emulation is on
// - D1H to 64H enters A20 sequence
module lke_emul (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Legacy port access
   input  wire lke_pkg::lke_port_req_t port_req,
   output logic      [7:0]            port_rdata,
   // Keyboard inhibit switch pin
   input  wire logic                  inhibit_off_pin,
   // Interrupt lines
   output logic                       irq1,
   output logic                       irq12,
   output logic                       emul_irq,
   output logic                       irq
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lke_pkg::lke_status_t        status;
   lke_pkg::lke_status_t        sw_status;
   logic [7:0]                  output_byte;
   logic [7:0]                  input_byte;
   logic                        legacy_emulation_on;
   logic                        char_waiting_irq_enable;
   logic                        legacy_irq_request_enable;
   logic                        addr_line_gate_sequence;
   logic                        a20_state;
   logic                        inhibit_off;
   logic                        setup;
   logic                        access;
   logic                        bus_wr;
   logic                        bus_rd;
   logic                        hit;
   logic                        next_hit;
   logic [31:0]                 next_rdata;
   logic                        wr_ctl;
   logic                        wr_out;
   logic                        wr_stat;
   logic                        wr_mask;
   logic                        rd_evt;
   logic                        io_wr_data;
   logic                        io_wr_cmd;
   logic                        io_rd_data;
   logic                        a20_write;
   logic                        fill_input;
   logic [lke_pkg::EV_NUM-1:0]  evt;
   logic [lke_pkg::EV_NUM-1:0]  evt_stat;
   logic [lke_pkg::EV_NUM-1:0]  evt_mask;
   logic [31:0]                 ctl_word;

   // ----------------------------------------
   // Inhibit switch synchroniser
   // ----------------------------------------
   lke_sync u_inhibit_sync (
      .mclk (mclk),
      .rst_n(rst_n),
      .din  (inhibit_off_pin),
      .dout (inhibit_off)
   );

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign bus_wr  = access & pwrite & hit;
   assign bus_rd  = access & ~pwrite & hit;
   // Every register answers at once: no wait states
   assign pready  = 1'b1;
   assign pslverr = access & ~hit;

   assign wr_ctl  = bus_wr & (paddr == lke_pkg::OFS_CONTROL);
   assign wr_out  = bus_wr & (paddr == lke_pkg::OFS_OUTPUT);
   assign wr_stat = bus_wr & (paddr == lke_pkg::OFS_STATUS);
   assign wr_mask = bus_wr & (paddr == lke_pkg::OFS_EVT_MASK);
   assign rd_evt  = bus_rd & (paddr == lke_pkg::OFS_EVT_STAT);

   always_comb begin
      ctl_word                              = 32'h0000_0000;
      ctl_word[lke_pkg::CTL_EMUL_ON]        = legacy_emulation_on;
      ctl_word[lke_pkg::CTL_EMUL_INT]       = emul_irq;
      ctl_word[lke_pkg::CTL_CHAR_WAIT]      = char_waiting_irq_enable;
      ctl_word[lke_pkg::CTL_IRQ_EN]         = legacy_irq_request_enable;
      ctl_word[lke_pkg::CTL_A20_SEQ]        = addr_line_gate_sequence;
      ctl_word[lke_pkg::CTL_A20_STATE]      = a20_state;
   end

   // Read data and address hit are prepared in the setup cycle
   always_comb begin
      next_hit   = 1'b1;
      next_rdata = 32'h0000_0000;
      case (paddr)
         lke_pkg::OFS_CONTROL:  next_rdata = ctl_word;
         lke_pkg::OFS_INPUT:    next_rdata = {24'h00_0000, input_byte};
         lke_pkg::OFS_OUTPUT:   next_rdata = {24'h00_0000, output_byte};
         lke_pkg::OFS_STATUS:   next_rdata = {24'h00_0000, status};
         lke_pkg::OFS_EVT_STAT: next_rdata = {28'h000_0000, evt_stat};
         lke_pkg::OFS_EVT_MASK: next_rdata = {28'h000_0000, evt_mask};
         default:               next_hit   = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         hit    <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0000_0000 : next_rdata;
         hit    <= next_hit;
      end
   end

   // ----------------------------------------
   // Legacy port decode
   // ----------------------------------------
   // decode only when on
   assign io_wr_data = legacy_emulation_on & port_req.wr & (port_req.addr == lke_pkg::PORT_DATA);
   assign io_wr_cmd  = legacy_emulation_on & port_req.wr & (port_req.addr == lke_pkg::PORT_CMD);
   assign io_rd_data = legacy_emulation_on & port_req.rd & (port_req.addr == lke_pkg::PORT_DATA);

   // A20 command itself, or the data byte that follows it
   assign a20_write  = (io_wr_cmd & (port_req.data == lke_pkg::CMD_A20_SEQ))
                     | (io_wr_data & addr_line_gate_sequence);
   assign fill_input = (io_wr_data | io_wr_cmd) & ~a20_write;

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         legacy_emulation_on       <= 1'b0;
         char_waiting_irq_enable   <= 1'b0;
         legacy_irq_request_enable <= 1'b0;
      end else if (wr_ctl) begin
         legacy_emulation_on       <= pwdata[lke_pkg::CTL_EMUL_ON];
         char_waiting_irq_enable   <= pwdata[lke_pkg::CTL_CHAR_WAIT];
         legacy_irq_request_enable <= pwdata[lke_pkg::CTL_IRQ_EN];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         addr_line_gate_sequence <= 1'b0;
      end else if (io_wr_cmd) begin
         addr_line_gate_sequence <= (port_req.data == lke_pkg::CMD_A20_SEQ);
      end
   end

   // Gate state follows the data byte of a sequence, or software
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         a20_state <= 1'b0;
      end else if (io_wr_data & addr_line_gate_sequence) begin
         a20_state <= port_req.data[lke_pkg::A20_DATA_BIT];
      end else if (wr_ctl) begin
         a20_state <= pwdata[lke_pkg::CTL_A20_STATE];
      end
   end

   // ----------------------------------------
   // Data bytes
   // ----------------------------------------
   // A20 writes land here too, so software sees them
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         input_byte <= lke_pkg::RST_BYTE;
      end else if (io_wr_data | io_wr_cmd) begin
         input_byte <= port_req.data;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         output_byte <= lke_pkg::RST_BYTE;
      end else if (wr_out) begin
         output_byte <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port_rdata <= lke_pkg::RST_BYTE;
      end else if (io_rd_data) begin
         port_rdata <= output_byte;
      end
   end

   // ----------------------------------------
   // Status register
   // ----------------------------------------
   // Software view of a status write, laid out like the register
   assign sw_status = lke_pkg::lke_status_t'(pwdata[7:0]);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.parity <= 1'b0;
      end else if (wr_stat) begin
         status.parity <= sw_status.parity;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.timeout <= 1'b0;
      end else if (wr_stat) begin
         status.timeout <= sw_status.timeout;
      end
   end

   // Aux flag steers the loaded byte to the mouse line
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.aux_full_flag <= 1'b0;
      end else if (wr_stat) begin
         status.aux_full_flag <= sw_status.aux_full_flag;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.sys_flag <= 1'b0;
      end else if (wr_stat) begin
         status.sys_flag <= sw_status.sys_flag;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.inhibit_off <= 1'b0;
      end else begin
         status.inhibit_off <= inhibit_off;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.cmd_data <= 1'b0;
      end else if (io_wr_cmd) begin
         status.cmd_data <= 1'b1;
      end else if (io_wr_data) begin
         status.cmd_data <= 1'b0;
      end else if (wr_stat) begin
         status.cmd_data <= sw_status.cmd_data;
      end
   end

   // port write other than A20 sets, wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.input_full <= 1'b0;
      end else if (fill_input) begin
         status.input_full <= 1'b1;
      end else if (wr_stat) begin
         status.input_full <= sw_status.input_full;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         status.result_buffer_loaded <= 1'b0;
      end else if (wr_stat) begin
         status.result_buffer_loaded <= sw_status.result_buffer_loaded;
      end else if (io_rd_data) begin
         status.result_buffer_loaded <= 1'b0;
      end
   end

   // ----------------------------------------
   // Legacy interrupt lines
   // ----------------------------------------
   // Legacy lines follow the enable alone, not emulation on
   // keyboard interrupt
   assign irq1  = legacy_irq_request_enable & ~status.aux_full_flag
                & status.result_buffer_loaded;
   assign irq12 = legacy_irq_request_enable & status.aux_full_flag
                & status.result_buffer_loaded;

   assign emul_irq = (legacy_emulation_on & status.input_full)
                   | (char_waiting_irq_enable & ~status.result_buffer_loaded);

   // ----------------------------------------
   // Event interrupt
   // ----------------------------------------
   always_comb begin
      evt                     = '0;
      evt[lke_pkg::EV_WR_DATA] = io_wr_data;
      evt[lke_pkg::EV_WR_CMD]  = io_wr_cmd;
      evt[lke_pkg::EV_RD_DATA] = io_rd_data;
      evt[lke_pkg::EV_A20]     = a20_write;
   end

   lke_evt_irq u_evt_irq (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .evt       (evt),
      .stat_rd   (rd_evt),
      .mask_wr   (wr_mask),
      .mask_wdata(pwdata[lke_pkg::EV_NUM-1:0]),
      .stat      (evt_stat),
      .mask      (evt_mask),
      .irq       (irq)
   );

endmodule // lke_emul

// ===== sim/lke_emul_sva.sv
`timescale 1ns/1ps
module lke_emul_sva (
   // Clock and reset
   input wire logic                   mclk,
   input wire logic                   rst_n,
   // APB slave
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // Legacy port and interrupts
   input wire lke_pkg::lke_port_req_t port_req,
   input wire logic [7:0]             port_rdata,
   input wire logic                   irq1,
   input wire logic                   irq12,
   input wire logic                   emul_irq,
   input wire logic                   irq
);
   // ----
   // Shadows of software writes
   // ----
   logic [8:0] ctl_sh;
   logic [7:0] out_sh;
   logic [3:0] mask_sh;
   wire acc    = psel && penable;
   wire wr_st  = acc && pwrite && paddr == lke_pkg::OFS_STATUS;
   wire wr_ctl = acc && pwrite && paddr == lke_pkg::OFS_CONTROL;
   wire hit    = paddr[11:5] == 7'h08 && paddr[4:2] < 3'h6 && paddr[1:0] == 2'h0;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_sh <= 9'h000;
         out_sh <= lke_pkg::RST_BYTE;
         mask_sh <= lke_pkg::RST_MASK;
      end else if (acc && pwrite) begin
         if (paddr == lke_pkg::OFS_CONTROL) ctl_sh <= pwdata[8:0];
         if (paddr == lke_pkg::OFS_OUTPUT) out_sh <= pwdata[7:0];
         if (paddr == lke_pkg::OFS_EVT_MASK) mask_sh <= pwdata[3:0];
      end
   end
   sequence rd60_s;
      port_req.rd && port_req.addr == lke_pkg::PORT_DATA && ctl_sh[0];
   endsequence
   sequence wr64_s;
      port_req.wr && port_req.addr == lke_pkg::PORT_CMD && port_req.data != lke_pkg::CMD_A20_SEQ && ctl_sh[0];
   endsequence
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ready_always_a: assert property (pready) else $error("pready low");
   unmapped_err_a: assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
   upper_zero_a: assert property (acc && !pwrite && (paddr == lke_pkg::OFS_OUTPUT || paddr == lke_pkg::OFS_STATUS)
      |-> prdata[31:8] == 24'h0) else $error("upper bits set");
   out_read_a: assert property (acc && !pwrite && paddr == lke_pkg::OFS_OUTPUT |-> prdata[7:0] == out_sh)
      else $error("output byte read wrong");
   rd60_data_a: assert property (rd60_s |=> port_rdata == $past(out_sh)) else $error("port read data wrong");
   rd60_clear_a: assert property (rd60_s ##0 !wr_st |=> !irq1 && !irq12) else $error("loaded not cleared");
   char_wait_a: assert property (rd60_s ##0 (ctl_sh[2] && !wr_ctl && !wr_st) |=> emul_irq) else $error("no char irq");
   irq_gate_a: assert property (irq1 || irq12 |-> ctl_sh[3]) else $error("irq without enable");
   wr64_irq_a: assert property (wr64_s ##0 !wr_ctl |=> emul_irq) else $error("no input irq");
   evt_irq_a: assert property (rd60_s ##0 mask_sh[2] |-> ##[1:3] irq) else $error("no event irq");
endmodule // lke_emul_sva
bind lke_emul lke_emul_sva chk_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_req(port_req),
   .port_rdata(port_rdata), .irq1(irq1), .irq12(irq12), .emul_irq(emul_irq), .irq(irq));

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [11:0] A_CT = lke_pkg::OFS_CONTROL;
   localparam logic [11:0] A_ST = lke_pkg::OFS_STATUS;
   localparam logic [11:0] A_OUT = lke_pkg::OFS_OUTPUT;
   localparam logic [7:0]  P60 = lke_pkg::PORT_DATA;
   localparam logic [7:0]  P64 = lke_pkg::PORT_CMD;
   logic                   mclk, rst_n, psel, penable, pwrite, pin, rd_d;
   logic                   pready, pslverr, irq1, irq12, emul_irq, irq;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, seed;
   logic [7:0]             port_rdata, r, b;
   lke_pkg::lke_port_req_t port_req;
   logic [32:0]            aq[$];
   logic [7:0]             pq[$];
   int                     n_mismatch, n_checks;
   lke_emul dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_req(port_req),
      .port_rdata(port_rdata), .inhibit_off_pin(pin), .irq1(irq1), .irq12(irq12), .emul_irq(emul_irq), .irq(irq));
   // ----
   // Tasks
   // ----
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(logic [32:0] got, logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic e = 1'b0);
      int k;
      @(posedge mclk);
      if (!w) aq.push_back({e, d});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge mclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_mismatch++;
         complete_run();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic port(logic rd, logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      if (rd) pq.push_back(d);
      port_req <= '{rd: rd, wr: !rd, addr: a, data: d};
      @(posedge mclk);
      port_req <= '0;
      @(posedge mclk);
      #1;
   endtask
   // ----
   // Result watcher and stimulus
   // ----
   always @(posedge mclk) begin
      rd_d <= port_req.rd && port_req.addr == P60;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (aq.size() == 0) n_mismatch++;
         else cmp({pslverr, prdata}, aq.pop_front());
      end
      if (rd_d === 1'b1) begin
         if (pq.size() == 0) n_mismatch++;
         else cmp(port_rdata, pq.pop_front());
      end
   end
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      complete_run();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
      port_req = '0;
      pin = 1'b1;
      seed = lfsr(32'h7163);
      r = seed[7:0];
      seed = lfsr(seed);
      b = (seed[7:0] == lke_pkg::CMD_A20_SEQ) ? 8'h00 : seed[7:0];
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (5) @(posedge mclk);
      apb(0, A_ST, 32'h10);
      apb(0, A_OUT, 32'h0);
      apb(0, 12'h118, 32'h0, 1'b1);
      port(0, P60, 8'h55);
      apb(0, A_ST, 32'h10);
      @(posedge mclk) pin <= 1'b0;
      repeat (5) @(posedge mclk);
      apb(0, A_ST, 32'h0);
      @(posedge mclk) pin <= 1'b1;
      repeat (5) @(posedge mclk);
      apb(1, A_CT, 32'h9);
      apb(1, A_OUT, {24'hffffff, r});
      apb(0, A_OUT, {24'h0, r});
      apb(1, A_ST, 32'h1);
      cmp(irq1, 1'b1);
      apb(1, A_ST, 32'h21);
      cmp({irq12, irq1}, 2'b10);
      port(1, P60, r);
      apb(0, A_ST, 32'h30);
      port(0, P60, b);
      apb(0, A_ST, 32'h32);
      cmp(emul_irq, 1'b1);
      apb(0, lke_pkg::OFS_INPUT, {24'h0, b});
      apb(1, A_ST, 32'h0);
      cmp(emul_irq, 1'b0);
      port(0, P64, lke_pkg::CMD_A20_SEQ);
      apb(0, A_ST, 32'h18);
      apb(0, A_CT, 32'h29);
      port(0, P60, 8'h02);
      apb(0, A_ST, 32'h10);
      apb(0, A_CT, 32'h129);
      port(0, P64, b);
      apb(0, A_ST, 32'h1a);
      apb(0, A_CT, 32'h10b);
      apb(1, A_ST, 32'hc4);
      apb(0, A_ST, 32'hd4);
      cmp(emul_irq, 1'b0);
      apb(1, A_CT, 32'h10d);
      cmp(emul_irq, 1'b1);
      apb(0, lke_pkg::OFS_EVT_STAT, 32'hf);
      apb(1, lke_pkg::OFS_EVT_MASK, 32'h4);
      port(0, P64, b);
      cmp(irq, 1'b0);
      port(1, P60, r);
      repeat (3) @(posedge mclk);
      cmp(irq, 1'b1);
      apb(0, lke_pkg::OFS_EVT_STAT, 32'h6);
      repeat (2) @(posedge mclk);
      cmp(irq, 1'b0);
      complete_run();
   end
endmodule // tb
